// *** hdl/sync_time_base_slot_timer.v ***
// Time base, slot counter and time-sensitive traffic settings of the switch
// ****************************************
// Summary of operation
// - Report packet per sync transmit when enabled
// - Second class priority match steers queue 4
// - First class priority match steers queue 5
// - Ingress checks length against size limit
// - Egress shaping uses same size limit
// - Read-only 32-bit time base, zero reset
// - Packet timestamps taken from time base
// - Add increment, default 40, each tick
// - Non-nominal increment only for adjust period
// - Tick counter 1..terminal advances slot number
// - Five-bit slot number, software read/write
// - Slot select: 3125, 3126, 3124, reserved
// - Alternative slot length for slot period
// - Macro slot 1, 2 or 4 ms
// - Class 5 slot fixed at 125 us
// ****************************************
`include "slot_timer_defines.vh"

module sync_time_base_slot_timer #(
  parameter MACRO_BASE_TICKS = `MACRO_BASE_US * `TICK_MHZ,
  parameter CLASS5_TICKS = `CLASS5_SLOT_US * `TICK_MHZ
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Ingress classification
  input wire rx_pkt_i,
  input wire [2:0] rx_pcp_i,
  input wire [11:0] rx_len_i,
  output reg rx_to_queue4_o,
  output reg rx_to_queue5_o,
  output reg rx_len_ok_o,
  output reg [31:0] rx_stamp_o,
  // Egress shaping and reporting
  input wire tx_check_i,
  input wire [11:0] tx_len_i,
  output reg tx_gate_ok_o,
  input wire tx_sync_pkt_i,
  output reg report_req_o,
  output reg [31:0] report_stamp_o,
  // Slot timing
  output reg tick_o,
  output reg slot_start_o,
  output reg macro_slot_start_o,
  output reg class5_slot_start_o
);

  localparam DIV = `CLK_MHZ / `TICK_MHZ;
  localparam [16:0] MACRO_TICKS = MACRO_BASE_TICKS[16:0];
  localparam [16:0] C5_TICKS = CLASS5_TICKS[16:0];

  // ****************************************
  // Helpers
  // ****************************************
  function [11:0] slot_terminal;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: slot_terminal = `SLOT_TICKS_LONG;
        2'h2: slot_terminal = `SLOT_TICKS_SHORT;
        default: slot_terminal = `SLOT_TICKS_NOM;
      endcase
    end
  endfunction

  function [18:0] macro_ticks;
    input [1:0] per;
    begin
      case (per)
        2'h1: macro_ticks = {1'b0, MACRO_TICKS, 1'b0};
        2'h2: macro_ticks = {MACRO_TICKS, 2'h0};
        default: macro_ticks = {2'h0, MACRO_TICKS};
      endcase
    end
  endfunction

  function prio_hit;
    input [2:0] pcp;
    input [2:0] field;
    begin
      prio_hit = (pcp == field);
    end
  endfunction

  // Limit is inclusive: a packet of exactly the limit passes
  function within_limit;
    input [11:0] len;
    input [11:0] limit;
    begin
      within_limit = (len <= limit);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg report_en_ff;
  reg [2:0] second_prio_ff;
  reg [2:0] first_prio_ff;
  reg [11:0] size_limit_ff;
  reg [31:0] time_base_ff;
  reg [5:0] incr_ff;
  reg [3:0] adj_period_ff;
  reg [3:0] adj_left_ff;
  reg [11:0] tick_cnt_ff;
  reg [4:0] slot_ff;
  reg [1:0] slot_sel_ff;
  reg [3:0] slot_period_ff;
  reg [3:0] slot_left_ff;
  reg [1:0] macro_per_ff;
  reg [18:0] macro_cnt_ff;
  reg [16:0] c5_cnt_ff;
  reg [7:0] div_ff;

  wire wr_report = reg_wr_i && (reg_addr_i == `OFS_REPORT_CTRL);
  wire wr_prio = reg_wr_i && (reg_addr_i == `OFS_PRIORITY);
  wire wr_size = reg_wr_i && (reg_addr_i == `OFS_MAX_SIZE);
  wire wr_step = reg_wr_i && (reg_addr_i == `OFS_STEP_ADJ);
  wire wr_slot = reg_wr_i && (reg_addr_i == `OFS_SLOT_COUNT);
  wire wr_sadj = reg_wr_i && (reg_addr_i == `OFS_SLOT_ADJ);

  // ****************************************
  // Tick and time base
  // ****************************************
  wire tick = (div_ff == DIV - 1);
  wire adj_active = (incr_ff != `RST_INCR) && (adj_left_ff != 4'h0);
  wire [5:0] eff_incr = adj_active ? incr_ff : `RST_INCR;
  wire slot_alt = (slot_left_ff != 4'h0);
  wire [11:0] terminal = slot_terminal(slot_alt ? slot_sel_ff : 2'h0);
  wire slot_end = tick && (tick_cnt_ff >= terminal);
  wire [18:0] macro_end = macro_ticks(macro_per_ff);
  wire macro_wrap = (macro_cnt_ff + 19'h0_0001 >= macro_end);
  wire c5_wrap = (c5_cnt_ff + 17'h0_0001 >= C5_TICKS);

  // Divider from the system clock down to the 25 MHz tick
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= tick ? 8'h00 : div_ff + 8'h01;
    end
  end

  // Time base cannot be written; it only advances
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_base_ff <= 32'h0000_0000;
    end else if (tick) begin
      time_base_ff <= time_base_ff + {26'h00_0000, eff_incr};
    end
  end

  // A write restarts the adjust count even while one is running
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adj_left_ff <= 4'h0;
    end else if (wr_step) begin
      adj_left_ff <= reg_wdata_i[`ADJ_PER_MSB:`ADJ_PER_LSB];
    end else if (tick && adj_active) begin
      adj_left_ff <= adj_left_ff - 4'h1;
    end
  end

  // ****************************************
  // Tick counter, slot number and slot lengths
  // ****************************************
  // A slot register write overrides a slot end in the same cycle
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= 12'h000;
      slot_ff <= 5'h00;
    end else if (wr_slot) begin
      tick_cnt_ff <= reg_wdata_i[`TICK_MSB:`TICK_LSB];
      slot_ff <= reg_wdata_i[`SLOT_MSB:0];
    end else if (slot_end) begin
      tick_cnt_ff <= 12'h001;
      slot_ff <= slot_ff + 5'h01;
    end else if (tick) begin
      tick_cnt_ff <= tick_cnt_ff + 12'h001;
    end
  end

  // Alternative slot length counts down once per finished slot
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_left_ff <= 4'h0;
    end else if (wr_sadj) begin
      slot_left_ff <= reg_wdata_i[`ADJ_PER_MSB:`ADJ_PER_LSB];
    end else if (slot_end && slot_alt) begin
      slot_left_ff <= slot_left_ff - 4'h1;
    end
  end

  // ****************************************
  // Macro slot and class 5 slot counters
  // ****************************************
  // A shorter macro period takes effect at once; a long count wraps at once
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      macro_cnt_ff <= 19'h0_0000;
      c5_cnt_ff <= 17'h0_0000;
    end else if (tick) begin
      macro_cnt_ff <= macro_wrap ? 19'h0_0000 : macro_cnt_ff + 19'h0_0001;
      c5_cnt_ff <= c5_wrap ? 17'h0_0000 : c5_cnt_ff + 17'h0_0001;
    end
  end

  // ****************************************
  // Timing pulses
  // ****************************************
  // All pulses coincide with the tick that ends their period
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
      slot_start_o <= 1'b0;
      macro_slot_start_o <= 1'b0;
      class5_slot_start_o <= 1'b0;
    end else begin
      tick_o <= tick;
      slot_start_o <= slot_end && !wr_slot;
      macro_slot_start_o <= tick && macro_wrap;
      class5_slot_start_o <= tick && c5_wrap;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      report_en_ff <= 1'b0;
      second_prio_ff <= `RST_SECOND_PRIO;
      first_prio_ff <= `RST_FIRST_PRIO;
      size_limit_ff <= `RST_MAX_SIZE;
    end else begin
      if (wr_report) begin
        report_en_ff <= reg_wdata_i[`REPORT_EN_BIT];
      end
      if (wr_prio) begin
        second_prio_ff <= reg_wdata_i[`SECOND_PRIO_MSB:`SECOND_PRIO_LSB];
        first_prio_ff <= reg_wdata_i[`FIRST_PRIO_MSB:`FIRST_PRIO_LSB];
      end
      if (wr_size) begin
        size_limit_ff <= reg_wdata_i[`SIZE_MSB:0];
      end
    end
  end

  // Adjust fields stay readable after their counts run out
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      incr_ff <= `RST_INCR;
      adj_period_ff <= 4'h0;
      slot_sel_ff <= 2'h0;
      slot_period_ff <= 4'h0;
      macro_per_ff <= 2'h0;
    end else begin
      if (wr_step) begin
        incr_ff <= reg_wdata_i[`INCR_MSB:0];
        adj_period_ff <= reg_wdata_i[`ADJ_PER_MSB:`ADJ_PER_LSB];
      end
      if (wr_sadj) begin
        slot_sel_ff <= reg_wdata_i[`SEL_MSB:0];
        slot_period_ff <= reg_wdata_i[`ADJ_PER_MSB:`ADJ_PER_LSB];
        macro_per_ff <= reg_wdata_i[`MACRO_MSB:`MACRO_LSB];
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped offsets read zero
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_REPORT_CTRL: reg_rdata_o <= {31'h0000_0000, report_en_ff};
        `OFS_PRIORITY: reg_rdata_o <= {26'h000_0000, second_prio_ff, first_prio_ff};
        `OFS_MAX_SIZE: reg_rdata_o <= {20'h0_0000, size_limit_ff};
        `OFS_TIME_BASE: reg_rdata_o <= time_base_ff;
        `OFS_STEP_ADJ: reg_rdata_o <= {20'h0_0000, adj_period_ff, 2'h0, incr_ff};
        `OFS_SLOT_COUNT: reg_rdata_o <= {4'h0, tick_cnt_ff, 11'h000, slot_ff};
        `OFS_SLOT_ADJ: reg_rdata_o <= {14'h0000, macro_per_ff, 4'h0, slot_period_ff,
          6'h00, slot_sel_ff};
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Ingress classification
  // ****************************************
  // Equal priorities: the first class wins, queue 4 stays clear
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_to_queue4_o <= 1'b0;
      rx_to_queue5_o <= 1'b0;
    end else begin
      rx_to_queue5_o <= rx_pkt_i && prio_hit(rx_pcp_i, first_prio_ff);
      rx_to_queue4_o <= rx_pkt_i && prio_hit(rx_pcp_i, second_prio_ff) &&
        !prio_hit(rx_pcp_i, first_prio_ff);
    end
  end

  // ****************************************
  // Length checks against the size limit
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_len_ok_o <= 1'b0;
      tx_gate_ok_o <= 1'b0;
    end else begin
      rx_len_ok_o <= rx_pkt_i && within_limit(rx_len_i, size_limit_ff);
      tx_gate_ok_o <= tx_check_i && within_limit(tx_len_i, size_limit_ff);
    end
  end

  // ****************************************
  // Timestamps and report requests
  // ****************************************
  // Stamps hold until the next capture
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_stamp_o <= 32'h0000_0000;
      report_req_o <= 1'b0;
      report_stamp_o <= 32'h0000_0000;
    end else begin
      if (rx_pkt_i) begin
        rx_stamp_o <= time_base_ff;
      end
      report_req_o <= tx_sync_pkt_i && report_en_ff;
      if (tx_sync_pkt_i) begin
        report_stamp_o <= time_base_ff;
      end
    end
  end

endmodule // sync_time_base_slot_timer

// *** hdl/slot_timer_defines.vh ***
// Register offsets, field positions, reset values and timing constants of the slot timer
`ifndef SLOT_TIMER_DEFINES_VH
`define SLOT_TIMER_DEFINES_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_REPORT_CTRL 8'h02
`define OFS_PRIORITY 8'h03
`define OFS_MAX_SIZE 8'h04
`define OFS_TIME_BASE 8'h10
`define OFS_STEP_ADJ 8'h14
`define OFS_SLOT_COUNT 8'h18
`define OFS_SLOT_ADJ 8'h1c
// ****************************************
// Field positions
// ****************************************
`define REPORT_EN_BIT 0
`define SECOND_PRIO_MSB 5
`define SECOND_PRIO_LSB 3
`define FIRST_PRIO_MSB 2
`define FIRST_PRIO_LSB 0
`define SIZE_MSB 11
`define INCR_MSB 5
`define ADJ_PER_MSB 11
`define ADJ_PER_LSB 8
`define TICK_MSB 27
`define TICK_LSB 16
`define SLOT_MSB 4
`define SEL_MSB 1
`define MACRO_MSB 17
`define MACRO_LSB 16
// ****************************************
// Reset values
// ****************************************
`define RST_SECOND_PRIO 3'h4
`define RST_FIRST_PRIO 3'h5
`define RST_MAX_SIZE 12'h05ee
`define RST_INCR 6'h28
// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 50
`define TICK_MHZ 25
`define SLOT_TICKS_NOM 12'h0c35
`define SLOT_TICKS_LONG 12'h0c36
`define SLOT_TICKS_SHORT 12'h0c34
`define MACRO_BASE_US 1000
`define CLASS5_SLOT_US 125
`endif

// *** tb/slot_timer_sva.sv ***
// Checker for the slot timer port behaviour
module slot_timer_sva #(
  parameter MACRO_BASE_TICKS = 10,
  parameter CLASS5_TICKS = 8
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Requests
  input wire rx_pkt_i,
  input wire tx_check_i,
  input wire tx_sync_pkt_i,
  // Answers
  input wire [31:0] rx_stamp_o,
  input wire rx_to_queue4_o,
  input wire rx_to_queue5_o,
  input wire rx_len_ok_o,
  input wire tx_gate_ok_o,
  input wire report_req_o,
  input wire tick_o,
  input wire slot_start_o,
  input wire class5_slot_start_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence idle_then_tick;
    !tick_o ##1 tick_o;
  endsequence
  sequence quiet_class5;
    !class5_slot_start_o [*8];
  endsequence
  a_tick_every_two: assert property (tick_o |=> idle_then_tick)
    else $error("tick spacing wrong");
  a_report_cause: assert property (report_req_o |-> $past(tx_sync_pkt_i))
    else $error("report without sync transmit");
  a_len_cause: assert property (rx_len_ok_o |-> $past(rx_pkt_i))
    else $error("length ok without packet");
  a_gate_cause: assert property (tx_gate_ok_o |-> $past(tx_check_i))
    else $error("gate ok without query");
  a_queue4_only: assert property (rx_to_queue4_o |-> !rx_to_queue5_o && $past(rx_pkt_i))
    else $error("queue 4 flag wrong");
  a_queue5_cause: assert property (rx_to_queue5_o |-> $past(rx_pkt_i))
    else $error("queue 5 without packet");
  a_stamp_hold: assert property (!$past(rx_pkt_i) |-> $stable(rx_stamp_o))
    else $error("stamp moved without packet");
  a_slot_on_tick: assert property (slot_start_o |-> tick_o)
    else $error("slot start off tick");
  a_class5_gap: assert property (class5_slot_start_o |-> tick_o ##1 quiet_class5)
    else $error("class 5 slot too short");
endmodule // slot_timer_sva
bind sync_time_base_slot_timer slot_timer_sva #(.MACRO_BASE_TICKS(MACRO_BASE_TICKS),
  .CLASS5_TICKS(CLASS5_TICKS)) u_sva (.*);

// *** tb/tb.sv ***
// Self-checking bench of the slot timer
`include "slot_timer_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic rx_pkt_i = 0, tx_check_i = 0, tx_sync_pkt_i = 0;
  logic [7:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, t0, rd;
  logic [2:0] rx_pcp_i = 0;
  logic [11:0] rx_len_i = 0, tx_len_i = 0;
  wire [31:0] reg_rdata_o, rx_stamp_o, report_stamp_o;
  wire rx_to_queue4_o, rx_to_queue5_o, rx_len_ok_o, tx_gate_ok_o, report_req_o;
  wire tick_o, slot_start_o, macro_slot_start_o, class5_slot_start_o;
  int errors = 0, n_tests = 0;
  sync_time_base_slot_timer #(.MACRO_BASE_TICKS(10), .CLASS5_TICKS(8)) dut (.*);
  initial forever #10 ref_clk_i = ~ref_clk_i;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    {reg_wr_i, reg_rd_i} = {w, !w};
    @(negedge ref_clk_i);
    {reg_wr_i, reg_rd_i} = 2'b00;
    rd = reg_rdata_o;
  endtask
  task automatic pk(input logic [2:0] c, input logic [11:0] l);
    @(negedge ref_clk_i);
    reg_addr_i = `OFS_TIME_BASE;
    {rx_pkt_i, tx_check_i, tx_sync_pkt_i, reg_rd_i} = 4'hf;
    rx_pcp_i = c;
    rx_len_i = l;
    tx_len_i = l;
    @(negedge ref_clk_i);
    {rx_pkt_i, tx_check_i, tx_sync_pkt_i, reg_rd_i} = 4'h0;
    chk("rx stamp", reg_rdata_o, rx_stamp_o);
    chk("report stamp", reg_rdata_o, report_stamp_o);
  endtask
  function automatic logic pul(input int k);
    return k == 0 ? slot_start_o : k == 1 ? macro_slot_start_o : class5_slot_start_o;
  endfunction
  task automatic gap(input int k, input int skip, input int e, input string nm);
    int n;
    n = 0;
    for (int s = 0; s <= skip; s++) begin
      do @(negedge ref_clk_i); while (pul(k) !== 1'b1);
    end
    do begin
      @(negedge ref_clk_i);
      n += (tick_o === 1'b1);
    end while (pul(k) !== 1'b1);
    chk(nm, e, n);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] a [6] = '{`OFS_REPORT_CTRL, `OFS_PRIORITY, `OFS_MAX_SIZE, `OFS_STEP_ADJ,
      `OFS_SLOT_ADJ, 8'h20};
    logic [31:0] e [6] = '{0, 32'h0000_0025, 32'h0000_05ee, 32'h0000_0028, 0, 0};
    for (int i = 0; i < 6; i++) begin
      acc(0, a[i], 0);
      chk("reset value", e[i], rd);
    end
    acc(0, `OFS_TIME_BASE, 0);
    t0 = rd;
    acc(1, `OFS_TIME_BASE, 0);
    acc(0, `OFS_TIME_BASE, 0);
    chk("time base", t0 + 32'd80, rd);
    $display("reset and base test done");
  endtask
  task automatic t_adjust;
    acc(0, `OFS_TIME_BASE, 0);
    t0 = rd;
    acc(1, `OFS_STEP_ADJ, 32'h0000_0329);
    repeat (16) @(negedge ref_clk_i);
    acc(0, `OFS_TIME_BASE, 0);
    chk("adjusted base", t0 + 32'd403, rd);
    t0 = rd;
    repeat (18) @(negedge ref_clk_i);
    acc(0, `OFS_TIME_BASE, 0);
    chk("nominal base", t0 + 32'd400, rd);
    acc(0, `OFS_STEP_ADJ, 0);
    chk("step adjust", 32'h0000_0329, rd);
    $display("adjust test done");
  endtask
  task automatic t_class;
    acc(1, `OFS_PRIORITY, 32'h0000_0016);
    for (int p = 0; p < 8; p++) begin
      pk(p[2:0], 12'd1515 + p[11:0]);
      chk("queue4", p == 2, rx_to_queue4_o);
      chk("queue5", p == 6, rx_to_queue5_o);
      chk("rx len ok", p < 4, rx_len_ok_o);
      chk("tx gate ok", p < 4, tx_gate_ok_o);
      chk("report off", 0, report_req_o);
    end
    acc(1, `OFS_MAX_SIZE, 32'h0000_f064);
    acc(0, `OFS_MAX_SIZE, 0);
    chk("size reg", 32'h0000_0064, rd);
    pk(3'd0, 12'd101);
    chk("tx gate 101", 0, tx_gate_ok_o);
    pk(3'd0, 12'd100);
    chk("rx len 100", 1, rx_len_ok_o);
    acc(1, `OFS_REPORT_CTRL, 32'hffff_ffff);
    acc(0, `OFS_REPORT_CTRL, 0);
    chk("report ctrl", 32'h0000_0001, rd);
    pk(3'd0, 12'd0);
    chk("report on", 1, report_req_o);
    $display("class and report test done");
  endtask
  task automatic t_slot;
    int e [3] = '{3125, 3126, 3124};
    for (int i = 0; i < 3; i++) begin
      acc(1, `OFS_SLOT_ADJ, 32'h0000_0200 | i);
      acc(1, `OFS_SLOT_COUNT, 32'h0c1c_001f);
      gap(0, 0, e[i], "slot ticks");
    end
    gap(0, 0, 3125, "nominal slot");
    acc(0, `OFS_SLOT_COUNT, 0);
    chk("slot number", 32'h0000_0003, rd & 32'h0000_001f);
    for (int i = 0; i < 3; i++) begin
      acc(1, `OFS_SLOT_ADJ, 32'(i) << 16);
      gap(1, 1, 10 << i, "macro ticks");
    end
    gap(2, 0, 8, "class5 ticks");
    $display("slot test done");
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    errors++;
    give_verdict;
  end
  initial begin
    repeat (5) @(negedge ref_clk_i);
    rst_n_i = 1;
    t_reset;
    t_adjust;
    t_class;
    t_slot;
    give_verdict;
  end
endmodule // tb
